// ==== verilog/uart_fmc_pkg.sv ====
/*
 Constants for the UART flow and modem control block.
 Assumes an AXI4-Lite master with 32-bit data and a single aclk domain.
*/
package uart_fmc_pkg;
	localparam logic [15:0] MODEM_CONTROL_OFS = 16'hFFA4;
	// Status, flow and state words take the next free aligned words
	localparam logic [15:0] MODEM_STATUS_OFS = 16'hFFA8;
	localparam logic [15:0] FLOW_CONTROL_LOW_OFS = 16'hFFAC;
	localparam logic [15:0] EVENT_OFS = 16'hFFB0;
	localparam int SOFT_RST_BIT = 0;
	localparam int RX_EN_BIT = 1;
	localparam int LOOP_BIT = 2;
	localparam int DTR_BIT = 4;
	localparam int RTS_BIT = 5;
	localparam int RING_LOOP_BIT = 6;
	localparam int CARRIER_LOOP_BIT = 7;
	localparam int TX_XOFF_BIT = 0;
	localparam int TX_XON_ANY_BIT = 1;
	localparam int TX_CTS_BIT = 2;
	localparam int TX_DSR_BIT = 3;
	localparam int RX_XOFF_BIT = 4;
	localparam int RX_RTS_BIT = 5;
	localparam int RX_DTR_BIT = 6;
	localparam int HALF_DUPLEX_BIT = 7;
	localparam int STAT_CTS_BIT = 4;
	localparam int STAT_DSR_BIT = 5;
	localparam int STAT_RING_BIT = 6;
	localparam int STAT_CARRIER_BIT = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	localparam logic [2:0] RESET_CYCLES = 3'h4;
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_WRESP = 2'b01,
		BUS_RRESP = 2'b10
	} bus_state_t;
endpackage

// ==== verilog/uart_sync2.sv ====
/*
 Two-stage synchroniser for a bundle of pin levels.
 Assumes inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_sync2 #(
	parameter int WIDTH = 6
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed
	{
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;
	sync_state_t st;
	sync_state_t next_st;
	always_comb
	begin
		next_st.first = async_in;
		next_st.second = st.first;
	end
	// Idle-high reset so pins read inactive until sampled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '{first: {WIDTH{1'b1}}, second: {WIDTH{1'b1}}};
		else
			st <= next_st;
	end
	assign sync_out = st.second;
endmodule
`default_nettype wire

// ==== verilog/uart_flow_modem_control.sv ====
/*
 UART flow-control, modem-control, soft-reset, RS-485 and loop-back logic
 with an AXI4-Lite register slave.
 Assumes modem pins are active low and asynchronous; the core UART supplies
 transmit serial data, FIFO full/empty, received Xon/Xoff and busy flags.
*/
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_flow_modem_control (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Modem pins, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic dcd_n,
	input wire logic ring_indicator_input_n,
	output logic dtr_n,
	output logic rts_n,
	// Serial pins
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	// UART core side
	input wire logic core_tx_serial,
	input wire logic core_tx_busy,
	input wire logic core_xoff_seen,
	input wire logic core_xon_seen,
	input wire logic core_rx_any,
	input wire logic core_fifo_full,
	input wire logic core_fifo_empty,
	output logic core_rx_serial,
	output logic core_rx_enable,
	output logic core_tx_allow,
	output logic core_send_req,
	output logic [7:0] core_send_char,
	output logic uart_reset_n
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		uart_fmc_pkg::bus_state_t bus;
		logic [31:0] rdata;
		logic [1:0] resp;
		logic awready;
		logic wready;
		logic arready;
		logic [7:0] modem_ctl;
		logic [7:0] flow_ctl;
		logic [2:0] rst_cnt;
		logic xoff_held;
		logic rx_full_held;
		logic rx_stop_prev;
		logic send_req;
		logic [7:0] send_char;
		logic dtr_n;
		logic rts_n;
		logic serial_out;
		logic rx_serial;
		logic rx_enable;
		logic tx_allow;
		logic uart_soft_reset_bit_n;
	} ctl_state_t;
	ctl_state_t st;
	ctl_state_t next_st;
	logic [5:0] pins_sync;
	logic cts_act;
	logic dsr_act;
	logic dcd_act;
	logic ri_act;
	logic serial_in_sync;
	logic auto_rts;
	logic auto_dtr;

	uart_sync2 #(
		.WIDTH(6)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({cts_n, dsr_n, dcd_n, ring_indicator_input_n, serial_in_pin, 1'b1}),
		.sync_out(pins_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of the low byte
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge8 = strb[0] ? d[7:0] : old;
	endfunction

	always_comb
	begin
		// Loop-back replaces pins by control bits as active levels
		if (st.modem_ctl[uart_fmc_pkg::LOOP_BIT])
		begin
			cts_act = st.modem_ctl[uart_fmc_pkg::DTR_BIT];
			dsr_act = st.modem_ctl[uart_fmc_pkg::RTS_BIT];
			ri_act = st.modem_ctl[uart_fmc_pkg::RING_LOOP_BIT];
			dcd_act = st.modem_ctl[uart_fmc_pkg::CARRIER_LOOP_BIT];
		end
		else
		begin
			cts_act = !pins_sync[5];
			dsr_act = !pins_sync[4];
			dcd_act = !pins_sync[3];
			ri_act = !pins_sync[2];
		end
		serial_in_sync = pins_sync[1];
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [7:0] wbyte;
		logic [15:0] waddr;
		logic tx_stop;
		logic hd;
		logic rx_stop;
		wbyte = 8'h00;
		waddr = s_axi_awaddr;
		tx_stop = 1'b0;
		hd = st.flow_ctl[uart_fmc_pkg::HALF_DUPLEX_BIT];
		rx_stop = 1'b0;
		next_st = st;
		next_st.awready = 1'b0;
		next_st.wready = 1'b0;
		next_st.arready = 1'b0;
		next_st.send_req = 1'b0;

		// Bus slave: write needs both channels, answered one cycle later
		case (st.bus)
			uart_fmc_pkg::BUS_IDLE:
			begin
				if (s_axi_awvalid && s_axi_wvalid)
				begin
					next_st.awready = 1'b1;
					next_st.wready = 1'b1;
					next_st.bus = uart_fmc_pkg::BUS_WRESP;
					next_st.resp = uart_fmc_pkg::RESP_OKAY;
					case (waddr)
						uart_fmc_pkg::MODEM_CONTROL_OFS:
						begin
							wbyte = merge8(st.modem_ctl, s_axi_wdata, s_axi_wstrb);
							// Writing zero to soft reset is ignored
							wbyte[uart_fmc_pkg::SOFT_RST_BIT] =
								st.modem_ctl[uart_fmc_pkg::SOFT_RST_BIT]
								| wbyte[uart_fmc_pkg::SOFT_RST_BIT];
							next_st.modem_ctl = wbyte;
							if (wbyte[uart_fmc_pkg::SOFT_RST_BIT] && st.rst_cnt == 3'h0)
								next_st.rst_cnt = uart_fmc_pkg::RESET_CYCLES;
						end
						uart_fmc_pkg::FLOW_CONTROL_LOW_OFS:
						begin
							wbyte = merge8(st.flow_ctl, s_axi_wdata, s_axi_wstrb);
							// Both Xon options at once is illegal; drop both, keep the rest
							if (wbyte[uart_fmc_pkg::TX_XON_ANY_BIT]
								&& wbyte[uart_fmc_pkg::TX_XOFF_BIT])
							begin
								wbyte[uart_fmc_pkg::TX_XON_ANY_BIT] = 1'b0;
								wbyte[uart_fmc_pkg::TX_XOFF_BIT] = 1'b0;
							end
							next_st.flow_ctl = wbyte;
						end
						uart_fmc_pkg::MODEM_STATUS_OFS,
						uart_fmc_pkg::EVENT_OFS:
							next_st.resp = uart_fmc_pkg::RESP_OKAY;
						default:
							next_st.resp = uart_fmc_pkg::RESP_SLVERR;
					endcase
				end
				else if (s_axi_arvalid)
				begin
					next_st.arready = 1'b1;
					next_st.bus = uart_fmc_pkg::BUS_RRESP;
					next_st.resp = uart_fmc_pkg::RESP_OKAY;
					next_st.rdata = 32'h0000_0000;
					case (s_axi_araddr)
						uart_fmc_pkg::MODEM_CONTROL_OFS:
							next_st.rdata[7:0] = st.modem_ctl;
						uart_fmc_pkg::FLOW_CONTROL_LOW_OFS:
							next_st.rdata[7:0] = st.flow_ctl;
						uart_fmc_pkg::MODEM_STATUS_OFS:
						begin
							next_st.rdata[uart_fmc_pkg::STAT_CTS_BIT] = cts_act;
							next_st.rdata[uart_fmc_pkg::STAT_DSR_BIT] = dsr_act;
							next_st.rdata[uart_fmc_pkg::STAT_RING_BIT] = ri_act;
							next_st.rdata[uart_fmc_pkg::STAT_CARRIER_BIT] = dcd_act;
						end
						uart_fmc_pkg::EVENT_OFS:
							next_st.rdata[3:0] = {st.rx_full_held, st.xoff_held,
								st.tx_allow, st.rx_enable};
						default:
							next_st.resp = uart_fmc_pkg::RESP_SLVERR;
					endcase
				end
			end
			uart_fmc_pkg::BUS_WRESP:
				if (s_axi_bready)
					next_st.bus = uart_fmc_pkg::BUS_IDLE;
			uart_fmc_pkg::BUS_RRESP:
				if (s_axi_rready)
					next_st.bus = uart_fmc_pkg::BUS_IDLE;
			default:
				next_st.bus = uart_fmc_pkg::BUS_IDLE;
		endcase

		// Soft reset: hold core reset a few cycles, then self-clear
		if (st.rst_cnt != 3'h0)
		begin
			next_st.rst_cnt = st.rst_cnt - 3'h1;
			next_st.uart_soft_reset_bit_n = 1'b0;
			next_st.xoff_held = 1'b0;
			next_st.rx_full_held = 1'b0;
			// Transmit flow mode returns to zero, as after a hard reset
			next_st.flow_ctl[uart_fmc_pkg::TX_XOFF_BIT] = 1'b0;
			next_st.flow_ctl[uart_fmc_pkg::TX_XON_ANY_BIT] = 1'b0;
			next_st.flow_ctl[uart_fmc_pkg::TX_CTS_BIT] = 1'b0;
			next_st.flow_ctl[uart_fmc_pkg::TX_DSR_BIT] = 1'b0;
			if (st.rst_cnt == 3'h1)
				next_st.modem_ctl[uart_fmc_pkg::SOFT_RST_BIT] = 1'b0;
		end
		else
		begin
			next_st.uart_soft_reset_bit_n = 1'b1;
			// Xoff tracking; Xon-on-any releases on any character
			if (core_xoff_seen && (st.flow_ctl[uart_fmc_pkg::TX_XOFF_BIT]
				|| st.flow_ctl[uart_fmc_pkg::TX_XON_ANY_BIT]))
				next_st.xoff_held = 1'b1;
			else if (core_xon_seen
				|| (st.flow_ctl[uart_fmc_pkg::TX_XON_ANY_BIT] && core_rx_any))
				next_st.xoff_held = 1'b0;
			// FIFO full latches the stop request until empty
			if (core_fifo_full)
				next_st.rx_full_held = 1'b1;
			else if (core_fifo_empty)
				next_st.rx_full_held = 1'b0;
		end

		// Transmit gating: any enabled source halts, all clear resumes
		if (st.flow_ctl[uart_fmc_pkg::TX_CTS_BIT] && !cts_act)
			tx_stop = 1'b1;
		if (st.flow_ctl[uart_fmc_pkg::TX_DSR_BIT] && !dsr_act)
			tx_stop = 1'b1;
		if (st.xoff_held)
			tx_stop = 1'b1;
		next_st.tx_allow = !tx_stop;

		// Receive flow: Xon/Xoff characters on edges of the full state
		rx_stop = st.rx_full_held;
		next_st.rx_stop_prev = rx_stop;
		if (st.flow_ctl[uart_fmc_pkg::RX_XOFF_BIT] && rx_stop != st.rx_stop_prev)
		begin
			next_st.send_req = 1'b1;
			next_st.send_char = rx_stop ? uart_fmc_pkg::XOFF_CHAR
				: uart_fmc_pkg::XON_CHAR;
		end

		// Modem outputs: RS-485 first, then auto flow, then manual
		// RS-485: RTS pin high while sending, DTR pin the opposite sense
		if (hd)
		begin
			next_st.rts_n = core_tx_busy;
			next_st.dtr_n = !core_tx_busy;
		end
		else
		begin
			next_st.rts_n = auto_rts ? !rx_stop
				: !st.modem_ctl[uart_fmc_pkg::RTS_BIT];
			next_st.dtr_n = auto_dtr ? !rx_stop
				: !st.modem_ctl[uart_fmc_pkg::DTR_BIT];
		end

		// Receiver enable in half duplex with RX_EN_BIT clear: off while the RTS pin is high
		if (hd && !st.modem_ctl[uart_fmc_pkg::RX_EN_BIT])
			next_st.rx_enable = !st.rts_n;
		else
			next_st.rx_enable = 1'b1;

		// Loop-back path; output pin idles high
		next_st.serial_out = st.modem_ctl[uart_fmc_pkg::LOOP_BIT] ? 1'b1
			: core_tx_serial;
		next_st.rx_serial = st.modem_ctl[uart_fmc_pkg::LOOP_BIT] ? core_tx_serial
			: serial_in_sync;
	end

	assign auto_rts = st.flow_ctl[uart_fmc_pkg::RX_RTS_BIT];
	assign auto_dtr = st.flow_ctl[uart_fmc_pkg::RX_DTR_BIT];

	////////////////////////////////////////////////////////////////////////
	// Soft reset leaves the register file alone except through rst_cnt
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.bus <= uart_fmc_pkg::BUS_IDLE;
			st.modem_ctl <= uart_fmc_pkg::REG_RESET;
			st.flow_ctl <= uart_fmc_pkg::REG_RESET;
			st.dtr_n <= 1'b1;
			st.rts_n <= 1'b1;
			st.serial_out <= 1'b1;
			st.rx_serial <= 1'b1;
			st.rx_enable <= 1'b1;
			st.tx_allow <= 1'b1;
			st.uart_soft_reset_bit_n <= 1'b0;
		end
		else
			st <= next_st;
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = (st.bus == uart_fmc_pkg::BUS_WRESP);
	assign s_axi_bresp = st.resp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = (st.bus == uart_fmc_pkg::BUS_RRESP);
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.resp;
	assign dtr_n = st.dtr_n;
	assign rts_n = st.rts_n;
	assign serial_out_pin = st.serial_out;
	assign core_rx_serial = st.rx_serial;
	assign core_rx_enable = st.rx_enable;
	assign core_tx_allow = st.tx_allow;
	assign core_send_req = st.send_req;
	assign core_send_char = st.send_char;
	assign uart_reset_n = st.uart_soft_reset_bit_n;
endmodule
`default_nettype wire

// ==== tb/uart_fmc_properties.sv ====
/*
 Checker for the flow and modem control block.
 Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_fmc_properties (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and core
	input wire logic serial_out_pin,
	input wire logic core_tx_serial,
	input wire logic core_send_req,
	input wire logic [7:0] core_send_char,
	input wire logic uart_reset_n
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////
	sequence s_idle;
		!s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !s_axi_arready;
	endsequence
	sequence s_soft_hold;
		(!uart_reset_n)[*4] ##[1:2] uart_reset_n;
	endsequence
	a_write_answer: assert property (s_idle ##0 s_axi_awvalid && s_axi_wvalid
		|=> s_axi_awready && s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_idle ##0 s_axi_arvalid && !(s_axi_awvalid && s_axi_wvalid)
		|=> s_axi_arready && s_axi_rvalid ##1 !s_axi_arready) else $error("read not answered");
	a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
		else $error("rvalid dropped");
	a_hard_release: assert property ($rose(aresetn) |-> !uart_reset_n ##[1:3] uart_reset_n)
		else $error("uart reset release wrong");
	a_soft_length: assert property ($fell(uart_reset_n) |-> s_soft_hold)
		else $error("soft reset length wrong");
	a_send_char: assert property (core_send_req |-> (core_send_char == uart_fmc_pkg::XON_CHAR
		|| core_send_char == uart_fmc_pkg::XOFF_CHAR) ##1 !core_send_req)
		else $error("bad flow character");
	a_loop_out: assert property (!serial_out_pin |-> !$past(core_tx_serial))
		else $error("serial out not from transmitter");
endmodule
bind uart_flow_modem_control uart_fmc_properties uart_fmc_properties_i (.*);
`default_nettype wire

// ==== tb/uart_modem_peer.sv ====
/*
 Far-side modem: drops its ready lines while told to stall.
 Assumes the bench owns the stall command; the line idles at mark.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_modem_peer (
	// Clock and command
	input wire logic aclk,
	input wire logic stall,
	// Modem lines
	input wire logic dtr_n,
	input wire logic rts_n,
	output logic cts_n,
	output logic dsr_n,
	output logic dcd_n,
	output logic ring_indicator_input_n,
	output logic serial_in_pin
);
	// Carrier follows terminal ready, as a dial-up modem would
	assign cts_n = stall;
	assign dsr_n = stall;
	assign dcd_n = dtr_n;
	assign ring_indicator_input_n = 1'b1;
	assign serial_in_pin = 1'b1;
endmodule
`default_nettype wire

// ==== tb/uart_flow_modem_control_tb.sv ====
/*
 Self-checking bench for the flow and modem control block.
 Assumes the modem peer model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_flow_modem_control_tb;
	typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_t;
	localparam logic [15:0] MC = uart_fmc_pkg::MODEM_CONTROL_OFS;
	localparam logic [15:0] FC = uart_fmc_pkg::FLOW_CONTROL_LOW_OFS;
	localparam logic [1:0] OK = uart_fmc_pkg::RESP_OKAY;
	logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cts_n, dsr_n, dcd_n, ring_indicator_input_n, dtr_n, rts_n;
	logic serial_in_pin, serial_out_pin, core_tx_serial = 1'b1, core_tx_busy = 1'b0;
	logic core_xoff_seen = 1'b0, core_xon_seen = 1'b0, core_rx_any = 1'b0;
	logic core_fifo_full = 1'b0, core_fifo_empty = 1'b1;
	logic core_rx_serial, core_rx_enable, core_tx_allow, core_send_req, uart_reset_n;
	logic [7:0] core_send_char;
	int err_total = 0, comparisons = 0, n, k;
	row_t rows [8] = '{'{FC, 8'h05, 8'h05, OK}, '{FC, 8'h03, 8'h00, OK},
		'{FC, 8'h0F, 8'h0C, OK}, '{FC, 8'h70, 8'h70, OK}, '{MC, 8'hB2, 8'hB2, OK},
		'{16'hFFB4, 8'h5A, 8'h00, uart_fmc_pkg::RESP_SLVERR}, '{MC, 8'h00, 8'h00, OK},
		'{FC, 8'h00, 8'h00, OK}};
	always #25 aclk = ~aclk;
	uart_flow_modem_control uart_flow_modem_control_i (.*);
	uart_modem_peer uart_modem_peer_i (.*);
	////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo();
		if (n == 40)
		begin
			err_total++;
			final_report();
		end
	endtask
	// One transfer; the response handshake closes it
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if ((w && s_axi_bvalid === 1'b1) || (!w && s_axi_rvalid === 1'b1))
				break;
		end
		rd = s_axi_rdata;
		rsp = w ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		tmo();
	endtask
	task automatic pulse(input logic [2:0] p);
		{core_xoff_seen, core_xon_seen, core_rx_any} <= p;
		@(posedge aclk);
		{core_xoff_seen, core_xon_seen, core_rx_any} <= 3'b000;
		repeat (4) @(posedge aclk);
	endtask
	// Pulse is one cycle wide, so poll every edge
	task automatic grab(input logic f, input logic [7:0] exp);
		core_fifo_full <= f;
		core_fifo_empty <= !f;
		for (n = 0; n < 40 && core_send_req !== 1'b1; n++)
			@(posedge aclk);
		tmo();
		chk(core_send_char, exp);
		repeat (4) @(posedge aclk);
	endtask
	////////////////////////////////
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		acc(1'b0, MC, 8'h00);
		chk(rd, 32'h00000000);
		acc(1'b0, FC, 8'h00);
		chk(rd, 32'h00000000);
		chk(core_tx_allow, 1'b1);
		foreach (rows[i])
		begin
			acc(1'b1, rows[i].a, rows[i].d);
			chk(rsp, rows[i].r);
			acc(1'b0, rows[i].a, 8'h00);
			chk(rd, rows[i].e);
			chk(rsp, rows[i].r);
		end
		$display("test rows done");
		acc(1'b1, MC, 8'h30);
		repeat (4) @(posedge aclk);
		chk({dtr_n, rts_n}, 2'b00);
		stall <= 1'b1;
		acc(1'b1, FC, 8'h0C);
		acc(1'b1, MC, 8'hF4);
		core_tx_serial <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({serial_out_pin, core_rx_serial}, 2'b10);
		chk(core_tx_allow, 1'b1);
		acc(1'b0, uart_fmc_pkg::MODEM_STATUS_OFS, 8'h00);
		chk(rd, 32'h000000F0);
		acc(1'b1, MC, 8'h04);
		repeat (4) @(posedge aclk);
		chk(core_tx_allow, 1'b0);
		acc(1'b1, MC, 8'h00);
		core_tx_serial <= 1'b1;
		$display("test loop done");
		acc(1'b1, FC, 8'h04);
		repeat (4) @(posedge aclk);
		chk(core_tx_allow, 1'b0);
		acc(1'b1, FC, 8'h08);
		repeat (4) @(posedge aclk);
		chk(core_tx_allow, 1'b0);
		acc(1'b1, FC, 8'h05);
		stall <= 1'b0;
		pulse(3'b100);
		chk(core_tx_allow, 1'b0);
		stall <= 1'b1;
		pulse(3'b010);
		chk(core_tx_allow, 1'b0);
		stall <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(core_tx_allow, 1'b1);
		acc(1'b1, FC, 8'h02);
		pulse(3'b100);
		chk(core_tx_allow, 1'b0);
		pulse(3'b001);
		chk(core_tx_allow, 1'b1);
		$display("test transmit flow done");
		acc(1'b1, FC, 8'h30);
		grab(1'b1, uart_fmc_pkg::XOFF_CHAR);
		chk(rts_n, 1'b0);
		grab(1'b0, uart_fmc_pkg::XON_CHAR);
		chk(rts_n, 1'b1);
		acc(1'b1, FC, 8'h60);
		core_fifo_full <= 1'b1;
		core_fifo_empty <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({dtr_n, rts_n}, 2'b00);
		core_fifo_full <= 1'b0;
		core_fifo_empty <= 1'b1;
		repeat (4) @(posedge aclk);
		chk({dtr_n, rts_n}, 2'b11);
		$display("test receive flow done");
		acc(1'b1, FC, 8'h00);
		core_tx_busy <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(core_rx_enable, 1'b1);
		acc(1'b1, FC, 8'h80);
		repeat (4) @(posedge aclk);
		chk({rts_n, dtr_n, core_rx_enable}, 3'b100);
		acc(1'b1, MC, 8'h02);
		repeat (4) @(posedge aclk);
		chk(core_rx_enable, 1'b1);
		core_tx_busy <= 1'b0;
		$display("test half duplex done");
		acc(1'b1, FC, 8'h05);
		acc(1'b1, MC, 8'h01);
		@(posedge aclk);
		chk(uart_reset_n, 1'b0);
		for (k = 0; k < 20; k++)
		begin
			acc(1'b0, MC, 8'h00);
			if (rd[0] === 1'b0)
				break;
		end
		chk(rd[0], 1'b0);
		chk(uart_reset_n, 1'b1);
		if (k == 20)
			final_report();
		acc(1'b0, FC, 8'h00);
		chk(rd, 32'h00000000);
		acc(1'b1, MC, 8'h30);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		acc(1'b0, MC, 8'h00);
		chk(rd, 32'h00000000);
		$display("test resets done");
		final_report();
	end
endmodule
`default_nettype wire
